// [design/pcl_program_counter.sv]
// program counter with high-address latch and circular return stack
// assumes req is synchronous to clock and holds at most one command per cycle
module pcl_program_counter #(
  parameter logic [12:0] VECTOR_ADDR = pcl_pkg::VECTOR_DEF
) (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire pcl_pkg::pcl_req_t  req,
  output pcl_pkg::pcl_view_t      view
);
  import pcl_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [HIGH_W-1:0] latch;
    logic [SP_W-1:0]   sp;
  } pcl_state_t;

  pcl_state_t      st_ff;
  pcl_state_t      nxt_st;
  logic [PC_W-1:0] stack_ff [STACK_D];
  logic            push;
  logic [PC_W-1:0] push_val;

  // split load shared by call and jump
  function automatic logic [PC_W-1:0] split_load(input logic [HIGH_W-1:0] l,
                                                 input logic [OPND_W-1:0] o);
    split_load = {l[HIGH_W-1:HIGH_W-2], o};
  endfunction : split_load

  // next state; latch only changes on its own write, never on push or pop
  always_comb
  begin
    nxt_st   = st_ff;
    push     = 1'b0;
    push_val = st_ff.pc;
    if (req.latch_wr)
    begin
      nxt_st.latch = req.latch_data; // only its own write moves it
    end
    unique case (req.cmd)
      PCL_CMD_NONE: ;
      PCL_CMD_FETCH:  nxt_st.pc = st_ff.pc + PC_ONE; // wraps in 13 bits
      PCL_CMD_LOW_WR: nxt_st.pc = {st_ff.latch, req.low_data};
      PCL_CMD_CALL:
      begin
        nxt_st.pc = split_load(st_ff.latch, req.operand);
        push      = 1'b1;
        push_val  = st_ff.pc + PC_ONE; // return to the next word
      end
      PCL_CMD_JUMP:   nxt_st.pc = split_load(st_ff.latch, req.operand);
      PCL_CMD_RETURN:
      begin
        nxt_st.sp = st_ff.sp - SP_ONE; // no underflow flag
        nxt_st.pc = stack_ff[st_ff.sp - SP_ONE];
      end
      PCL_CMD_VECTOR:
      begin
        nxt_st.pc = VECTOR_ADDR;
        push      = 1'b1; // interrupted word resumes
      end
      default: nxt_st = st_ff;
    endcase
    if (push)
    begin
      nxt_st.sp = st_ff.sp + SP_ONE; // wraps, overwriting oldest
    end
  end

  // state register; reset clears counter
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '{pc: PC_RST, latch: LATCH_RST, sp: SP_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // stack storage is not reset; contents are undefined until pushed
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      stack_ff[st_ff.sp] <= push_val;
    end
  end

  // registered view of the counter
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      view <= '{pc: PC_RST, pc_low_byte: 8'h00, pc_high_latch: LATCH_RST};
    end
    else
    begin
      view <= '{pc: nxt_st.pc, pc_low_byte: nxt_st.pc[LOW_W-1:0],
                pc_high_latch: nxt_st.latch};
    end
  end

  sequence s_call;
    req.cmd == PCL_CMD_CALL;
  endsequence

  a_call_split: assert property (@(posedge clock) disable iff (!rst_b)
    s_call |=> st_ff.pc == {$past(st_ff.latch[4:3]), $past(req.operand)})
    else $error("call load wrong");
  a_jump_split: assert property (@(posedge clock) disable iff (!rst_b)
    req.cmd == PCL_CMD_JUMP |=> st_ff.pc[10:0] == $past(req.operand))
    else $error("jump load wrong");
  a_low_write: assert property (@(posedge clock) disable iff (!rst_b)
    req.cmd == PCL_CMD_LOW_WR |=> st_ff.pc == {$past(st_ff.latch), $past(req.low_data)})
    else $error("low write wrong");
  a_fetch_inc: assert property (@(posedge clock) disable iff (!rst_b)
    req.cmd == PCL_CMD_FETCH |=> st_ff.pc == $past(st_ff.pc) + PC_ONE)
    else $error("fetch increment wrong");
  a_latch_keep: assert property (@(posedge clock) disable iff (!rst_b)
    !req.latch_wr |=> st_ff.latch == $past(st_ff.latch))
    else $error("latch moved");
  a_call_return: assert property (@(posedge clock) disable iff (!rst_b)
    s_call ##1 (req.cmd == PCL_CMD_RETURN) |=> st_ff.pc == $past(st_ff.pc, 2) + PC_ONE)
    else $error("return address wrong");
  a_stack_wrap: assert property (@(posedge clock) disable iff (!rst_b)
    push |=> st_ff.sp == $past(st_ff.sp) + SP_ONE)
    else $error("stack pointer wrong");
  a_view_match: assert property (@(posedge clock) disable iff (!rst_b)
    view.pc == st_ff.pc && view.pc_low_byte == st_ff.pc[7:0])
    else $error("view mismatch");
  a_reset_zero: assert property (@(posedge clock)
    $rose(rst_b) |-> st_ff.pc == PC_RST)
    else $error("reset not cleared");

  // further command steps, one named sequence per kind of command except fetch
  sequence s_jump;
    req.cmd == PCL_CMD_JUMP;
  endsequence

  sequence s_low_wr;
    req.cmd == PCL_CMD_LOW_WR;
  endsequence

  sequence s_ret;
    req.cmd == PCL_CMD_RETURN;
  endsequence

  sequence s_vector;
    req.cmd == PCL_CMD_VECTOR;
  endsequence

  sequence s_idle;
    req.cmd == PCL_CMD_NONE;
  endsequence

  // the operand fills the lower eleven bits on a call
  a_call_low: assert property (@(posedge clock) disable iff (!rst_b)
    s_call |=> st_ff.pc[OPND_W-1:0] == $past(req.operand))
    else $error("call operand bits wrong");

  // a jump keeps the top two bits from the old latch, even with a latch write
  a_jump_top: assert property (@(posedge clock) disable iff (!rst_b)
    s_jump |=> st_ff.pc[PC_W-1:OPND_W] == $past(st_ff.latch[HIGH_W-1:HIGH_W-2]))
    else $error("jump top bits wrong");

  // a low-byte write copies all five latch bits into the upper counter bits
  a_low_upper: assert property (@(posedge clock) disable iff (!rst_b)
    s_low_wr |=> st_ff.pc[PC_W-1:LOW_W] == $past(st_ff.latch))
    else $error("upper bits not from latch");

  // the call stores the word after the call for the later return
  a_call_push: assert property (@(posedge clock) disable iff (!rst_b)
    s_call |=> stack_ff[$past(st_ff.sp)] == $past(st_ff.pc) + PC_ONE)
    else $error("call push wrong");

  // a vector stores the interrupted word itself
  a_vector_push: assert property (@(posedge clock) disable iff (!rst_b)
    s_vector |=> stack_ff[$past(st_ff.sp)] == $past(st_ff.pc))
    else $error("vector push wrong");

  // a vector jumps to the fixed entry address
  a_vector_load: assert property (@(posedge clock) disable iff (!rst_b)
    s_vector |=> st_ff.pc == VECTOR_ADDR)
    else $error("vector load wrong");

  // a pop steps the pointer back, wrapping below zero without a flag
  a_return_pop: assert property (@(posedge clock) disable iff (!rst_b)
    s_ret |=> st_ff.sp == $past(st_ff.sp) - SP_ONE)
    else $error("pop pointer wrong");

  // the pointer only moves on a push or a pop
  a_sp_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (!push && req.cmd != PCL_CMD_RETURN) |=> $stable(st_ff.sp))
    else $error("pointer moved without push or pop");

  // push and pop leave the latch alone unless it is written in that cycle
  a_push_latch: assert property (@(posedge clock) disable iff (!rst_b)
    ((push || req.cmd == PCL_CMD_RETURN) && !req.latch_wr) |=> $stable(st_ff.latch))
    else $error("latch moved on push or pop");

  // an idle cycle holds the counter
  a_hold_idle: assert property (@(posedge clock) disable iff (!rst_b)
    s_idle |=> $stable(st_ff.pc))
    else $error("counter moved while idle");

  // fetch at the top of the space wraps to zero, no carry out
  a_fetch_wrap: assert property (@(posedge clock) disable iff (!rst_b)
    (req.cmd == PCL_CMD_FETCH && st_ff.pc == '1) |=> st_ff.pc == PC_RST)
    else $error("fetch wrap wrong");

  // the latch seen outside is the one used for loads
  a_view_latch: assert property (@(posedge clock) disable iff (!rst_b)
    view.pc_high_latch == st_ff.latch)
    else $error("latch view mismatch");
endmodule : pcl_program_counter

// [design/pcl_pkg.sv]
// constants and carrier types for the program counter loading block
// assumes one core instruction clock and an execution unit that drives one command per cycle
// What this block does
// - hold a 13-bit counter, low byte readable and writable
// - upper five bits never written directly; a low-byte write loads them from the high latch, call and jump take bits 10:8 from the operand
// - any reset clears the whole counter
// - low-byte destination loads upper bits from latch bits 4:0
// - low-byte write sets all 13 bits at once
// - call loads bits 10:0 from the operand
// - call takes bits 12:11 from latch bits 4:3
// - absolute jump loads like a call
// - call or interrupt vector pushes the full counter on an 8-deep stack
// - push and pop leave the high latch untouched
// - stack is circular, ninth push overwrites first, no flags
package pcl_pkg;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned LOW_W      = 8;
  localparam int unsigned HIGH_W     = 5;
  localparam int unsigned OPND_W     = 11;
  localparam int unsigned STACK_D    = 8;
  localparam int unsigned SP_W       = 3;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  localparam logic [HIGH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [PC_W-1:0] VECTOR_DEF = 13'h0004;

  // one command per cycle from the execution unit
  typedef enum logic [6:0] {
    PCL_CMD_NONE   = 7'b0000001,
    PCL_CMD_FETCH  = 7'b0000010,
    PCL_CMD_LOW_WR = 7'b0000100,
    PCL_CMD_CALL   = 7'b0001000,
    PCL_CMD_JUMP   = 7'b0010000,
    PCL_CMD_RETURN = 7'b0100000,
    PCL_CMD_VECTOR = 7'b1000000
  } pcl_cmd_t;

  typedef struct packed {
    pcl_cmd_t          cmd;
    logic [LOW_W-1:0]  low_data;
    logic [OPND_W-1:0] operand;
    logic              latch_wr;
    logic [HIGH_W-1:0] latch_data;
  } pcl_req_t;

  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [LOW_W-1:0]  pc_low_byte;
    logic [HIGH_W-1:0] pc_high_latch;
  } pcl_view_t;
endpackage : pcl_pkg

// [sim/pcl_exec_model.sv]
// stand-in for the execution unit, one command per cycle
// assumes the bench calls issue just after a rising edge
module pcl_exec_model
  import pcl_pkg::*;
(
  input  wire logic clock,
  output pcl_req_t  req
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle until told otherwise
  initial req = {PCL_CMD_NONE, 25'h0};
  // held unchanged until the next call
  task automatic issue(input pcl_req_t r);
    req = r;
  endtask : issue
endmodule : pcl_exec_model

// [sim/tb.sv]
// self-checking bench for the program counter block
// assumes the design package is compiled first
module tb;
  import pcl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0;
  logic        rst_b = 0;
  pcl_req_t    req;
  pcl_view_t   view;
  logic [12:0] mpc;
  logic [12:0] stk [8];
  logic [4:0]  mlat;
  logic [2:0]  sp;
  logic [31:0] lf = 32'h40b66ff3;
  int          n_fail = 0;
  int          n_compared = 0;
  int          dep = 0;
  int          cyc = 0;
  always #5 clock = ~clock;
  pcl_program_counter DUT (.clock(clock), .rst_b(rst_b), .req(req), .view(view));
  pcl_exec_model P (.clock(clock), .req(req));
  function automatic pcl_req_t mk(pcl_cmd_t c, logic [7:0] d, logic [10:0] o, logic w,
                                  logic [4:0] l);
    return '{c, d, o, w, l};
  endfunction : mk
  // next value of the bench random source
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // drive one command, advance the reference, compare after the edge
  task automatic step(input pcl_req_t r);
    P.issue(r);
    case (r.cmd)
      PCL_CMD_FETCH: mpc = mpc + 13'h1;
      PCL_CMD_LOW_WR: mpc = {mlat, r.low_data};
      PCL_CMD_JUMP: mpc = {mlat[4:3], r.operand};
      PCL_CMD_CALL, PCL_CMD_VECTOR:
      begin
        stk[sp] = (r.cmd == PCL_CMD_CALL) ? mpc + 13'h1 : mpc;
        sp++;
        dep = (dep < 8) ? dep + 1 : 8;
        mpc = (r.cmd == PCL_CMD_CALL) ? {mlat[4:3], r.operand} : VECTOR_DEF;
      end
      PCL_CMD_RETURN:
      begin
        sp--;
        dep--;
        mpc = stk[sp];
      end
      default: ;
    endcase
    if (r.latch_wr) mlat = r.latch_data;
    @(posedge clock);
    #1;
    check("pc", view.pc, mpc);
    check("low", {5'h0, view.pc_low_byte}, {5'h0, mpc[7:0]});
    check("latch", {8'h0, view.pc_high_latch}, {8'h0, mlat});
  endtask : step
  // cut a hang short
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    int k;
    for (int t = 0; t < 2; t++)
    begin
      mpc = 13'h0;
      mlat = 5'h0;
      sp = 3'h0;
      dep = 0;
      repeat (2) @(posedge clock);
      #1 rst_b = 1;
      check("rst", view.pc, 13'h0);
      // wrap the stack: nine pushes then eight pops
      for (int i = 0; i < 17; i++)
        step(mk(i < 9 ? PCL_CMD_CALL : PCL_CMD_RETURN, 8'h0, 11'(i * 37), 1'b1, 5'(i)));
      // computed jump crossing a page: latch bumped by software first
      step(mk(PCL_CMD_NONE, 8'h0, 11'h0, 1'b1, 5'h04));
      step(mk(PCL_CMD_LOW_WR, 8'h10, 11'h0, 1'b0, 5'h0));
      for (int i = 0; i < 300; i++)
      begin
        lf = lfsr(lf);
        k = lf[10:8] % 7;
        if (k == 5 && dep == 0) k = 1;
        step(mk(pcl_cmd_t'(7'h1 << k), lf[15:8], lf[26:16], lf[27], lf[4:0]));
      end
      $display("pass %0d done", t);
      // second pass starts from a reset in mid-run
      step(mk(PCL_CMD_NONE, 8'h0, 11'h0, 1'b0, 5'h0));
      rst_b = 0;
      #1 check("async", view.pc, 13'h0);
    end
    final_report();
  end
endmodule : tb
